//--- design/jtid_tap_fsm.sv
// Sixteen-state test access port controller.
// Assumes TMS is launched by the tester against the test clock.
`timescale 1ns/1ns

module jtid_tap_fsm (
    // Test clock and reset
    input wire logic tck,
    input wire logic rst,
    // Mode select
    input wire logic tms,
    // Controller state
    output jtid_pkg::jtid_tap_e state
);

    jtid_pkg::jtid_tap_e next_state;

    always_comb
    begin
        case (state)
            jtid_pkg::TAP_RESET: next_state = tms ? jtid_pkg::TAP_RESET : jtid_pkg::TAP_IDLE;
            jtid_pkg::TAP_IDLE: next_state = tms ? jtid_pkg::TAP_SEL_DR : jtid_pkg::TAP_IDLE;
            jtid_pkg::TAP_SEL_DR: next_state = tms ? jtid_pkg::TAP_SEL_IR : jtid_pkg::TAP_CAP_DR;
            jtid_pkg::TAP_CAP_DR: next_state = tms ? jtid_pkg::TAP_EX1_DR : jtid_pkg::TAP_SH_DR;
            jtid_pkg::TAP_SH_DR: next_state = tms ? jtid_pkg::TAP_EX1_DR : jtid_pkg::TAP_SH_DR;
            jtid_pkg::TAP_EX1_DR: next_state = tms ? jtid_pkg::TAP_UP_DR : jtid_pkg::TAP_PA_DR;
            jtid_pkg::TAP_PA_DR: next_state = tms ? jtid_pkg::TAP_EX2_DR : jtid_pkg::TAP_PA_DR;
            jtid_pkg::TAP_EX2_DR: next_state = tms ? jtid_pkg::TAP_UP_DR : jtid_pkg::TAP_SH_DR;
            jtid_pkg::TAP_UP_DR: next_state = tms ? jtid_pkg::TAP_SEL_DR : jtid_pkg::TAP_IDLE;
            jtid_pkg::TAP_SEL_IR: next_state = tms ? jtid_pkg::TAP_RESET : jtid_pkg::TAP_CAP_IR;
            jtid_pkg::TAP_CAP_IR: next_state = tms ? jtid_pkg::TAP_EX1_IR : jtid_pkg::TAP_SH_IR;
            jtid_pkg::TAP_SH_IR: next_state = tms ? jtid_pkg::TAP_EX1_IR : jtid_pkg::TAP_SH_IR;
            jtid_pkg::TAP_EX1_IR: next_state = tms ? jtid_pkg::TAP_UP_IR : jtid_pkg::TAP_PA_IR;
            jtid_pkg::TAP_PA_IR: next_state = tms ? jtid_pkg::TAP_EX2_IR : jtid_pkg::TAP_PA_IR;
            jtid_pkg::TAP_EX2_IR: next_state = tms ? jtid_pkg::TAP_UP_IR : jtid_pkg::TAP_SH_IR;
            jtid_pkg::TAP_UP_IR: next_state = tms ? jtid_pkg::TAP_SEL_DR : jtid_pkg::TAP_IDLE;
            default: next_state = jtid_pkg::TAP_RESET;
        endcase
    end

    always_ff @(posedge tck)
    begin
        if (rst)
            state <= jtid_pkg::TAP_RESET;
        else
            state <= next_state;
    end

    sequence five_ones_s;
        tms [*5];
    endsequence

    tap_reset_walk_a: assert property (@(posedge tck) disable iff (rst)
        five_ones_s |=> state == jtid_pkg::TAP_RESET)
        else $error("Five TMS ones did not reach test-logic-reset");

    tap_capture_a: assert property (@(posedge tck) disable iff (rst)
        (state == jtid_pkg::TAP_SEL_DR && !tms) |=> state == jtid_pkg::TAP_CAP_DR
        ##1 (state == jtid_pkg::TAP_SH_DR || state == jtid_pkg::TAP_EX1_DR))
        else $error("Data column entry order broken");

endmodule // jtid_tap_fsm

//--- design/jtid_top.sv
// Instruction register, chain selection and boundary cells of the test port.
// Assumes tck from the tester; debug words cross to sys_clk by toggle handshake.
`timescale 1ns/1ns

module jtid_top (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Test port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo,
    output logic tdo_oe,
    // Pads
    input wire logic [jtid_pkg::PAD_COUNT-1:0] pad_in,
    input wire logic rst_pin_n,
    output jtid_pkg::jtid_drive_s pad_drive,
    // Core
    input wire jtid_pkg::jtid_drive_s core_drive,
    output logic [jtid_pkg::PAD_COUNT-1:0] core_in,
    // Debug access side
    output logic dbg_req,
    output jtid_pkg::jtid_xfer_s dbg_xfer,
    input wire logic dbg_resp_valid,
    input wire logic [jtid_pkg::DBG_LEN-1:0] dbg_resp_word
);

    localparam int P = jtid_pkg::PAD_COUNT;
    localparam int CPP = jtid_pkg::CELLS_PER_PAD;
    localparam int BL = jtid_pkg::BSR_LEN;
    localparam int DL = jtid_pkg::DBG_LEN;

    // Test-domain reset from TRST and power-on
    logic [1:0] trst_q;
    logic [1:0] por_q;
    logic tck_rst;

    always_ff @(posedge tck)
    begin
        trst_q <= {trst_q[0], trst_n};
        por_q <= {por_q[0], sys_rst};
    end

    assign tck_rst = !trst_q[1] || por_q[1];

    // Controller
    jtid_pkg::jtid_tap_e state;

    jtid_tap_fsm u_fsm (
        .tck(tck),
        .rst(tck_rst),
        .tms(tms),
        .state(state)
    );

    // Instruction chain and holding register
    logic [jtid_pkg::IR_LEN-1:0] ir_sh;
    logic [jtid_pkg::IR_LEN-1:0] ir_hold;
    jtid_pkg::jtid_chain_e sel;
    logic extest;
    logic intest;

    always_ff @(posedge tck)
    begin
        if (tck_rst)
            ir_sh <= jtid_pkg::IR_IDCODE;
        else if (state == jtid_pkg::TAP_CAP_IR)
            ir_sh <= jtid_pkg::IR_CAPTURE;
        else if (state == jtid_pkg::TAP_SH_IR)
            ir_sh <= {tdi, ir_sh[jtid_pkg::IR_LEN-1:1]};
    end

    // Falling-edge load keeps the instruction steady across the rising edge
    always_ff @(negedge tck)
    begin
        if (tck_rst || state == jtid_pkg::TAP_RESET)
            ir_hold <= jtid_pkg::IR_IDCODE;
        else if (state == jtid_pkg::TAP_UP_IR)
            ir_hold <= ir_sh;
    end

    assign sel = jtid_pkg::chain_of(ir_hold);
    assign extest = ir_hold == jtid_pkg::IR_EXTEST;
    assign intest = ir_hold == jtid_pkg::IR_INTEST;

    // Pad and core levels brought into the test domain
    logic [P-1:0] pad_q1;
    logic [P-1:0] pad_q2;
    jtid_pkg::jtid_drive_s cd_q1;
    jtid_pkg::jtid_drive_s cd_q2;
    logic rpin_q1;
    logic rpin_q2;

    always_ff @(posedge tck)
    begin
        pad_q1 <= pad_in;
        pad_q2 <= pad_q1;
        cd_q1 <= core_drive;
        cd_q2 <= cd_q1;
        rpin_q1 <= rst_pin_n;
        rpin_q2 <= rpin_q1;
    end

    // Boundary chain
    logic [BL-1:0] bsr_sh;
    logic [BL-1:0] cap_vec;
    logic [jtid_pkg::PAD_CELLS-1:0] bsr_upd;
    logic [P-1:0] upd_out;
    logic [P-1:0] upd_oe;
    logic [P-1:0] upd_in;

    assign cap_vec[jtid_pkg::RST_CELL] = rpin_q2;

    genvar k;
    generate
        for (k = 0; k < P; k++)
        begin : g_pad
            assign upd_in[k] = bsr_upd[k*CPP + jtid_pkg::CELL_IN];
            assign upd_out[k] = bsr_upd[k*CPP + jtid_pkg::CELL_OUT];
            assign upd_oe[k] = bsr_upd[k*CPP + jtid_pkg::CELL_OE];
            assign cap_vec[k*CPP + jtid_pkg::CELL_IN] = pad_q2[k];
            assign cap_vec[k*CPP + jtid_pkg::CELL_OUT] = extest ? upd_out[k] : cd_q2.data[k];
            assign cap_vec[k*CPP + jtid_pkg::CELL_OE] = extest ? upd_oe[k] : cd_q2.oe[k];
            assign pad_drive.data[k] = extest ? upd_out[k] : core_drive.data[k];
            assign pad_drive.oe[k] = extest ? upd_oe[k] : core_drive.oe[k];
            assign core_in[k] = intest ? upd_in[k] : pad_in[k];
        end
    endgenerate

    always_ff @(posedge tck)
    begin
        if (tck_rst)
            bsr_sh <= '0;
        else if (sel == jtid_pkg::CH_BSR && state == jtid_pkg::TAP_CAP_DR)
            bsr_sh <= cap_vec;
        else if (sel == jtid_pkg::CH_BSR && state == jtid_pkg::TAP_SH_DR)
            bsr_sh <= {tdi, bsr_sh[BL-1:1]};
    end

    // Reset cell has no holding stage, so it can never reach the core
    always_ff @(negedge tck)
    begin
        if (tck_rst)
            bsr_upd <= '0;
        else if (sel == jtid_pkg::CH_BSR && state == jtid_pkg::TAP_UP_DR)
            bsr_upd <= bsr_sh[jtid_pkg::PAD_CELLS-1:0];
    end

    // Identification and bypass chains
    logic [jtid_pkg::ID_LEN-1:0] id_sh;
    logic byp_sh;

    always_ff @(posedge tck)
    begin
        if (tck_rst)
            id_sh <= jtid_pkg::ID_VALUE;
        else if (sel == jtid_pkg::CH_ID && state == jtid_pkg::TAP_CAP_DR)
            id_sh <= jtid_pkg::ID_VALUE;
        else if (sel == jtid_pkg::CH_ID && state == jtid_pkg::TAP_SH_DR)
            id_sh <= {tdi, id_sh[jtid_pkg::ID_LEN-1:1]};
    end

    always_ff @(posedge tck)
    begin
        if (tck_rst)
            byp_sh <= 1'b0;
        else if (sel == jtid_pkg::CH_BYP && state == jtid_pkg::TAP_CAP_DR)
            byp_sh <= 1'b0;
        else if (sel == jtid_pkg::CH_BYP && state == jtid_pkg::TAP_SH_DR)
            byp_sh <= tdi;
    end

    // Debug chains: abort, debug-port access, access-port access
    logic [DL-1:0] dbg_sh [jtid_pkg::DBG_CHAINS];
    logic [DL-1:0] resp_tck;
    logic [1:0] port;

    assign port = sel[1:0];

    genvar g;
    generate
        for (g = 0; g < jtid_pkg::DBG_CHAINS; g++)
        begin : g_dbg
            always_ff @(posedge tck)
            begin
                if (tck_rst)
                    dbg_sh[g] <= '0;
                else if (sel == jtid_pkg::jtid_chain_e'(g) && state == jtid_pkg::TAP_CAP_DR)
                    dbg_sh[g] <= resp_tck;
                else if (sel == jtid_pkg::jtid_chain_e'(g) && state == jtid_pkg::TAP_SH_DR)
                    dbg_sh[g] <= {tdi, dbg_sh[g][DL-1:1]};
            end
        end
    endgenerate

    // Debug word handed to the system domain on update
    jtid_pkg::jtid_xfer_s xfer_q;
    logic req_tgl;
    logic dbg_update;

    assign dbg_update = state == jtid_pkg::TAP_UP_DR && sel < jtid_pkg::CH_BSR;

    always_ff @(posedge tck)
    begin
        if (tck_rst)
        begin
            xfer_q <= '0;
            req_tgl <= 1'b0;
        end
        else if (dbg_update)
        begin
            xfer_q <= {port, dbg_sh[port]};
            req_tgl <= !req_tgl;
        end
    end

    logic [2:0] req_sync;
    logic req_seen;

    assign req_seen = req_sync[2] ^ req_sync[1];

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            req_sync <= '0;
        else
            req_sync <= {req_sync[1:0], req_tgl};
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            dbg_req <= 1'b0;
            dbg_xfer <= '0;
        end
        else
        begin
            dbg_req <= req_seen;
            if (req_seen)
                dbg_xfer <= xfer_q;
        end
    end

    // Response word returned to the test domain for the next capture
    logic [DL-1:0] resp_word;
    logic resp_tgl;
    logic [2:0] resp_sync;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            resp_word <= '0;
            resp_tgl <= 1'b0;
        end
        else if (dbg_resp_valid)
        begin
            resp_word <= dbg_resp_word;
            resp_tgl <= !resp_tgl;
        end
    end

    always_ff @(posedge tck)
    begin
        if (tck_rst)
        begin
            resp_sync <= '0;
            resp_tck <= '0;
        end
        else
        begin
            resp_sync <= {resp_sync[1:0], resp_tgl};
            if (resp_sync[2] ^ resp_sync[1])
                resp_tck <= resp_word;
        end
    end

    // Serial output, launched on the falling edge
    logic next_tdo;
    logic shifting;

    assign shifting = state == jtid_pkg::TAP_SH_DR || state == jtid_pkg::TAP_SH_IR;

    always_comb
    begin
        if (state == jtid_pkg::TAP_SH_IR)
            next_tdo = ir_sh[0];
        else
        begin
            case (sel)
                jtid_pkg::CH_BSR: next_tdo = bsr_sh[0];
                jtid_pkg::CH_ID: next_tdo = id_sh[0];
                jtid_pkg::CH_BYP: next_tdo = byp_sh;
                default: next_tdo = dbg_sh[port][0];
            endcase
        end
    end

    always_ff @(negedge tck)
    begin
        if (tck_rst)
        begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else
        begin
            tdo <= next_tdo;
            tdo_oe <= shifting;
        end
    end

    // Checks in the test domain
    ir_update_a: assert property (@(posedge tck) disable iff (tck_rst)
        state == jtid_pkg::TAP_UP_IR |=> ir_hold == $past(ir_sh))
        else $error("Instruction not loaded from shift chain on update");

    ir_shift_hold_a: assert property (@(posedge tck) disable iff (tck_rst)
        state == jtid_pkg::TAP_SH_IR |=> $stable(ir_hold))
        else $error("Instruction changed while shifting");

    ir_default_a: assert property (@(posedge tck) disable iff (tck_rst)
        state == jtid_pkg::TAP_RESET |=> ir_hold == jtid_pkg::IR_IDCODE)
        else $error("Identification not forced in test-logic-reset");

    pad_drive_a: assert property (@(posedge tck) disable iff (tck_rst)
        extest |-> pad_drive.data == upd_out && pad_drive.oe == upd_oe)
        else $error("Pads not driven from preload under pad-drive");

    core_drive_a: assert property (@(posedge tck) disable iff (tck_rst)
        intest |-> core_in == upd_in)
        else $error("Core inputs not driven from preload under core-drive");

    reserved_bypass_a: assert property (@(posedge tck) disable iff (tck_rst)
        ir_hold inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hD}
        |-> sel == jtid_pkg::CH_BYP)
        else $error("Unassigned code not decoded as bypass");

    sequence bsr_capture_s;
        sel == jtid_pkg::CH_BSR && state == jtid_pkg::TAP_CAP_DR;
    endsequence

    sequence bsr_shift_s;
        sel == jtid_pkg::CH_BSR && state == jtid_pkg::TAP_SH_DR;
    endsequence

    bsr_capture_a: assert property (@(posedge tck) disable iff (tck_rst)
        bsr_capture_s |=> bsr_sh == $past(cap_vec))
        else $error("Boundary capture missed pad values");

    bsr_shift_a: assert property (@(posedge tck) disable iff (tck_rst)
        bsr_shift_s |=> bsr_sh == {$past(tdi), $past(bsr_sh[BL-1:1])})
        else $error("Boundary chain did not shift one bit");

    bsr_update_a: assert property (@(posedge tck) disable iff (tck_rst)
        sel == jtid_pkg::CH_BSR && state == jtid_pkg::TAP_UP_DR
        |=> bsr_upd == $past(bsr_sh[jtid_pkg::PAD_CELLS-1:0]))
        else $error("Boundary holding register not updated");

    id_capture_a: assert property (@(posedge tck) disable iff (tck_rst)
        sel == jtid_pkg::CH_ID && state == jtid_pkg::TAP_CAP_DR |=> id_sh[0] ##0 id_sh[31:1] ==
        jtid_pkg::ID_VALUE[31:1])
        else $error("Identification capture wrong");

    byp_capture_a: assert property (@(posedge tck) disable iff (tck_rst)
        sel == jtid_pkg::CH_BYP && state == jtid_pkg::TAP_CAP_DR ##1 state == jtid_pkg::TAP_SH_DR
        |-> byp_sh == 1'b0)
        else $error("Bypass stage did not capture zero");

endmodule // jtid_top

//--- pkg/jtid_pkg.sv
// Constants, types and decode for the test-port instruction and data chains.
// Assumes a test clock from the external tester and a slower system clock.

package jtid_pkg;

    localparam int IR_LEN = 4;
    localparam int ID_LEN = 32;
    localparam int DBG_LEN = 35;
    localparam int DBG_CHAINS = 3;
    localparam int PAD_COUNT = 4;
    localparam int CELLS_PER_PAD = 3;
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;
    localparam int PAD_CELLS = PAD_COUNT * CELLS_PER_PAD;
    localparam int RST_CELL = PAD_CELLS;
    localparam int BSR_LEN = PAD_CELLS + 1;

    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_INTEST = 4'h1;
    localparam logic [3:0] IR_SAMPLE = 4'h2;
    localparam logic [3:0] IR_ABORT = 4'h8;
    localparam logic [3:0] IR_DEBUG_PORT_ACCESS_CHAIN = 4'hA;
    localparam logic [3:0] IR_ACCESS_PORT_ACCESS_CHAIN = 4'hB;
    localparam logic [3:0] IR_IDCODE = 4'hE;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_CAPTURE = 4'h1;

    // Arbitrary identification value; bit 0 must stay set
    localparam logic [31:0] ID_VALUE = 32'h1357_9BDF;

    typedef enum logic [3:0] {
        TAP_RESET = 4'hF, TAP_IDLE = 4'hC, TAP_SEL_DR = 4'h7, TAP_CAP_DR = 4'h6,
        TAP_SH_DR = 4'h2, TAP_EX1_DR = 4'h1, TAP_PA_DR = 4'h3, TAP_EX2_DR = 4'h0,
        TAP_UP_DR = 4'h5, TAP_SEL_IR = 4'h4, TAP_CAP_IR = 4'hE, TAP_SH_IR = 4'hA,
        TAP_EX1_IR = 4'h9, TAP_PA_IR = 4'hB, TAP_EX2_IR = 4'h8, TAP_UP_IR = 4'hD
    } jtid_tap_e;

    typedef enum logic [2:0] {
        CH_ABORT = 3'h0, CH_DEBUG_PORT_ACCESS_CHAIN = 3'h1, CH_ACCESS_PORT_ACCESS_CHAIN = 3'h2,
        CH_BSR = 3'h3, CH_ID = 3'h4, CH_BYP = 3'h5
    } jtid_chain_e;

    typedef struct packed {
        logic [1:0] port;
        logic [DBG_LEN-1:0] word;
    } jtid_xfer_s;

    typedef struct packed {
        logic [PAD_COUNT-1:0] data;
        logic [PAD_COUNT-1:0] oe;
    } jtid_drive_s;

    function automatic jtid_chain_e chain_of(input logic [3:0] ir);
        case (ir)
            IR_EXTEST, IR_INTEST, IR_SAMPLE: chain_of = CH_BSR;
            IR_ABORT: chain_of = CH_ABORT;
            IR_DEBUG_PORT_ACCESS_CHAIN: chain_of = CH_DEBUG_PORT_ACCESS_CHAIN;
            IR_ACCESS_PORT_ACCESS_CHAIN: chain_of = CH_ACCESS_PORT_ACCESS_CHAIN;
            IR_IDCODE: chain_of = CH_ID;
            default: chain_of = CH_BYP;
        endcase
    endfunction

endpackage

//--- verification/jtid_instruction_decode_chains_test.sv
// Self-checking bench for the test-port instruction decode and data chains.
// Assumes the adapter model drives the test port; bench drives pads and core.
`timescale 1ns/1ns

`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end

module jtid_instruction_decode_chains_test;
    logic sys_clk;
    logic sys_rst;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic tdo;
    logic tdo_oe;
    logic [jtid_pkg::PAD_COUNT-1:0] pad_in;
    logic rst_pin_n;
    jtid_pkg::jtid_drive_s pad_drive;
    jtid_pkg::jtid_drive_s core_drive;
    logic [jtid_pkg::PAD_COUNT-1:0] core_in;
    logic dbg_req;
    jtid_pkg::jtid_xfer_s dbg_xfer;
    logic dbg_resp_valid;
    logic [jtid_pkg::DBG_LEN-1:0] dbg_resp_word;
    int err_total = 0;
    int samples_checked = 0;
    int req_seen = 0;
    jtid_pkg::jtid_xfer_s req_last = '0;
    logic [34:0] sh_out;

    jtid_top uut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in),
        .rst_pin_n(rst_pin_n), .pad_drive(pad_drive), .core_drive(core_drive),
        .core_in(core_in), .dbg_req(dbg_req), .dbg_xfer(dbg_xfer),
        .dbg_resp_valid(dbg_resp_valid), .dbg_resp_word(dbg_resp_word)
    );

    jtid_tester adapter (
        .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever
            #50 sys_clk = ~sys_clk;
    end

    // Debug requests are single-cycle pulses; catch them whatever the bench is doing
    always @(posedge sys_clk)
    begin
        if (dbg_req === 1'b1)
        begin
            req_seen <= req_seen + 1;
            req_last <= dbg_xfer;
        end
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    function automatic logic [12:0] cells(input logic [3:0] pi, input logic [3:0] d,
            input logic [3:0] oe, input logic r);
        cells[12] = r;
        for (int k = 0; k < 4; k++)
            cells[3*k +: 3] = {oe[k], d[k], pi[k]};
    endfunction

    task automatic chk_id();
        adapter.scan(1'b0, 32, 35'h0, sh_out);
        `CHK(sh_out[31:0], jtid_pkg::ID_VALUE)
        `CHK(sh_out[0], 1'b1)
    endtask

    task automatic t_ident();
        chk_id();
        adapter.scan(1'b1, 4, 35'hF, sh_out);
        `CHK(sh_out[3:0], 4'h1)
        adapter.reset_tap(1'b0);
        chk_id();
        adapter.scan(1'b1, 4, 35'hF, sh_out);
        adapter.reset_tap(1'b1);
        chk_id();
        adapter.scan(1'b1, 4, 35'hF, sh_out);
        @(negedge sys_clk);
        sys_rst = 1'b1;
        adapter.idle(6);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        adapter.idle(4);
        chk_id();
    endtask

    task automatic t_bypass();
        logic [3:0] codes [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hD, 4'hF};
        adapter.gap = 200;
        foreach (codes[i])
        begin
            adapter.scan(1'b1, 4, 35'(codes[i]), sh_out);
            adapter.scan(1'b0, 2, 35'h1, sh_out);
            `CHK(sh_out[1:0], 2'b10)
        end
        adapter.gap = 0;
    endtask

    task automatic t_boundary();
        logic [12:0] pre;
        logic [3:0] pd;
        logic [3:0] po;
        logic [3:0] pi;
        pre = 13'h1_A5B;
        for (int k = 0; k < 4; k++)
        begin
            pi[k] = pre[3*k];
            pd[k] = pre[3*k+1];
            po[k] = pre[3*k+2];
        end
        @(negedge sys_clk);
        pad_in = 4'h6;
        rst_pin_n = 1'b0;
        core_drive = 8'hC5;
        repeat (4)
            @(negedge sys_clk);
        adapter.scan(1'b1, 4, 35'h2, sh_out);
        adapter.scan(1'b0, 13, 35'(pre), sh_out);
        `CHK(sh_out[12:0], cells(4'h6, 4'hC, 4'h5, 1'b0))
        `CHK(pad_drive, core_drive)
        adapter.scan(1'b1, 4, 35'h0, sh_out);
        `CHK(pad_drive, {pd, po})
        `CHK(core_in, pad_in)
        adapter.scan(1'b0, 13, 35'(pre), sh_out);
        `CHK(sh_out[12:0], cells(4'h6, pd, po, 1'b0))
        // New pad and reset pin levels: core must still see the preload
        @(negedge sys_clk);
        pad_in = 4'h9;
        rst_pin_n = 1'b1;
        adapter.scan(1'b1, 4, 35'h1, sh_out);
        `CHK(core_in, pi)
        `CHK(pad_drive, core_drive)
        adapter.scan(1'b0, 13, 35'(pre), sh_out);
        `CHK(sh_out[12:0], cells(4'h9, 4'hC, 4'h5, 1'b1))
    endtask

    task automatic dbg_scan(input logic [34:0] w, input logic [1:0] p);
        int n;
        n = req_seen;
        adapter.scan(1'b0, 35, w, sh_out);
        for (int t = 0; t < 40 && req_seen == n; t++)
            @(posedge sys_clk);
        if (req_seen == n)
        begin
            err_total++;
            conclude();
        end
        `CHK(req_last, {p, w})
    endtask

    task automatic t_debug();
        logic [3:0] codes [3] = '{4'h8, 4'hA, 4'hB};
        logic [34:0] w;
        for (int i = 0; i < 3; i++)
        begin
            w = 35'h5_0A0B_0C00 + 35'(i);
            adapter.scan(1'b1, 4, 35'(codes[i]), sh_out);
            dbg_scan(w, 2'(i));
            @(negedge sys_clk);
            dbg_resp_valid = 1'b1;
            dbg_resp_word = ~w;
            @(negedge sys_clk);
            dbg_resp_valid = 1'b0;
            adapter.idle(4);
            dbg_scan(w, 2'(i));
            `CHK(sh_out, ~w)
        end
    endtask

    initial
    begin
        sys_rst = 1'b1;
        pad_in = 4'h0;
        rst_pin_n = 1'b1;
        core_drive = 8'h00;
        dbg_resp_valid = 1'b0;
        dbg_resp_word = 35'h0;
        repeat (16)
            @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        adapter.reset_tap(1'b1);
        t_ident();
        t_bypass();
        t_boundary();
        t_debug();
        `CHK(adapter.oe_err, 0)
        conclude();
    end
endmodule // jtid_instruction_decode_chains_test

//--- verification/jtid_tester.sv
// Behavioural test adapter: runs tck only inside frames, steers tms and tdi.
// Assumes the device samples on rising tck and moves tdo on falling tck.
`timescale 1ns/1ns

module jtid_tester (
    // Test port
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe
);
    int oe_err = 0;
    int gap = 0;
    // Output enable is unknown until the first test reset has been clocked in
    logic armed = 1'b0;

    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end

    // One test clock; tdo read just before the rising edge
    task automatic step(input logic m, input logic d, input logic sh, output logic q);
        #(gap);
        tms = m;
        // Outside shifting tdi keeps moving so no stale bit looks valid
        tdi = sh ? d : ~tdi;
        #40;
        q = tdo;
        if (armed && tdo_oe !== sh)
            oe_err++;
        tck = 1'b1;
        #40;
        tck = 1'b0;
    endtask

    task automatic nav(input logic m);
        logic q;
        step(m, 1'b0, 1'b0, q);
    endtask

    task automatic idle(input int n);
        repeat (n)
            nav(1'b0);
    endtask

    // Full scan from idle or reset, back to idle; bits go LSB first
    task automatic scan(input logic ir, input int n, input logic [34:0] din,
            output logic [34:0] dout);
        logic q;
        dout = '0;
        nav(1'b0);
        nav(1'b1);
        if (ir)
            nav(1'b1);
        nav(1'b0);
        nav(1'b0);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], 1'b1, q);
            dout[i] = q;
        end
        nav(1'b1);
        nav(1'b0);
    endtask

    task automatic reset_tap(input logic hard);
        trst_n = ~hard;
        repeat (5)
            nav(1'b1);
        trst_n = 1'b1;
        repeat (3)
            nav(1'b1);
        armed = 1'b1;
    endtask
endmodule // jtid_tester
